/* clksm_consts.vh */
/*
  Constants of the clock source and synchronisation status block: register offsets, field positions, reset
  values and timing figures. Assumes it is included by bare name from the design files of the block.
*/
// Function
// RULE1: Sample clock comes from internal generator, MADI, word clock or AES input.
// RULE2: Operate and accept references only between 28 kHz and 200 kHz.
// RULE3: Lock once tracked period matches; keep lock through small period changes.
// RULE4: Each reference reports no lock, lock or sync to software.
// RULE5: Locked and synchronous with processing clock gives sync; otherwise lock only.
// RULE6: Valid locked MADI input shows lock for MADI.
// RULE7: Master mode runs internal clock; follow mode runs from the external reference.
// RULE8: Word clock output can be driven from the clock recovered from MADI.
// RULE9: Word clock output follows the active sample rate within 28 to 200 kHz.
// RULE10: Word clock input detects double or quad rate and converts to single speed.
// RULE11: Lock and sync status re-evaluated continuously and readable at any time.
`ifndef CLKSM_CONSTS_VH
`define CLKSM_CONSTS_VH
`define CLKSM_SYS_HZ 200000000
`define CLKSM_RATE_MIN_HZ 28000
`define CLKSM_RATE_MAX_HZ 200000
`define CLKSM_SS_MAX_HZ 56000
`define CLKSM_DS_MAX_HZ 112000
`define CLKSM_LOCK_PERIODS 3'h4
`define CLKSM_TRACK_TOL 16'h0008
`define CLKSM_SYNC_TOL 16'h0001
`define CLKSM_REG_CTRL 4'h0
`define CLKSM_REG_RATE 4'h4
`define CLKSM_REG_STATUS 4'h8
`define CLKSM_REG_PERIOD 4'hC
`define CLKSM_CTRL_SRC_LSB 0
`define CLKSM_CTRL_FOLLOW_BIT 2
`define CLKSM_CTRL_WCMADI_BIT 3
`define CLKSM_CTRL_RESET 4'h0
`define CLKSM_RATE_RESET 16'h1046
`define CLKSM_SRC_INT 2'h0
`define CLKSM_SRC_MADI 2'h1
`define CLKSM_SRC_WC 2'h2
`define CLKSM_SRC_AES 2'h3
`define CLKSM_ST_NOLOCK 2'h0
`define CLKSM_ST_LOCK 2'h1
`define CLKSM_ST_SYNC 2'h2
`endif

/* clksm_ref_meter.v */
/*
  Measures one external clock reference and decides its lock state.
  Assumes the reference pin is asynchronous to sys_clk and at most a quarter of its rate.
*/
`timescale 1ns/1ps
`include "clksm_consts.vh"
module clksm_ref_meter #(
  parameter W = 16,
  parameter CONVERT = 0,
  parameter [W-1:0] MIN_PER = 16'd1000,
  parameter [W-1:0] MAX_PER = 16'd7142,
  parameter [W-1:0] SS_PER = 16'd3571,
  parameter [W-1:0] DS_PER = 16'd1785
) (
  input wire sys_clk,
  input wire nrst,
  input wire ref_pin,
  output reg locked,
  output reg tick,
  output reg [W-1:0] period
);
  localparam [W-1:0] TOL = `CLKSM_TRACK_TOL;
  localparam [2:0] LOCK_N = `CLKSM_LOCK_PERIODS;
  reg s1, s2, s3;
  reg [W-1:0] raw_cnt;
  reg [W-1:0] tick_cnt;
  reg [1:0] div_cnt;
  reg [1:0] div_max;
  reg [2:0] good_cnt;
  reg [1:0] next_div_max;
  wire edge_seen = s2 & ~s3;
  wire [W-1:0] raw = raw_cnt + {{(W-1){1'b0}}, 1'b1};
  wire [W-1:0] tper = tick_cnt + {{(W-1){1'b0}}, 1'b1};
  wire in_range = (raw >= MIN_PER) && (raw <= MAX_PER);
  wire [W-1:0] diff = (tper > period) ? tper - period : period - tper;
  wire div_done = (div_cnt == div_max);

  always @* begin
    next_div_max = 2'd0;
    if (CONVERT != 0) begin
      if (raw < DS_PER)
        next_div_max = 2'd3; // RULE10
      else if (raw < SS_PER)
        next_div_max = 2'd1; // RULE10
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      raw_cnt <= {W{1'b0}};
      tick_cnt <= {W{1'b0}};
      div_cnt <= 2'd0;
      div_max <= 2'd0;
      good_cnt <= 3'd0;
      locked <= 1'b0;
      tick <= 1'b0;
      period <= {W{1'b0}};
    end else begin
      s1 <= ref_pin;
      s2 <= s1;
      s3 <= s2;
      tick <= 1'b0;
      if (tick_cnt != {W{1'b1}})
        tick_cnt <= tper;
      if (edge_seen) begin
        raw_cnt <= {W{1'b0}};
        if (!in_range) begin
          locked <= 1'b0; // RULE2
          good_cnt <= 3'd0;
          div_cnt <= 2'd0;
        end else if (next_div_max != div_max) begin
          div_max <= next_div_max;
          div_cnt <= 2'd0;
          good_cnt <= 3'd0;
          locked <= 1'b0;
        end else if (div_done) begin
          div_cnt <= 2'd0;
          tick <= 1'b1;
          tick_cnt <= {W{1'b0}};
          period <= tper;
          // Lock is kept while the period drifts by no more than the tracking window.
          if (diff <= TOL) begin
            if (good_cnt == LOCK_N)
              locked <= 1'b1; // RULE3
            else
              good_cnt <= good_cnt + 3'd1;
          end else begin
            good_cnt <= 3'd0;
            locked <= 1'b0; // RULE3
          end
        end else
          div_cnt <= div_cnt + 2'd1;
      end else if (raw_cnt > MAX_PER) begin
        locked <= 1'b0; // RULE2
        good_cnt <= 3'd0;
        div_cnt <= 2'd0;
      end else
        raw_cnt <= raw;
    end
  end
endmodule // clksm_ref_meter

/* clksm_top.v */
/*
  Sample clock selection, lock and sync status monitor, and word clock output.
  Assumes a register master on sys_clk and reference pins asynchronous to sys_clk.
*/
`timescale 1ns/1ps
`include "clksm_consts.vh"
module clksm_top #(
  parameter SYS_HZ = `CLKSM_SYS_HZ,
  parameter MIN_HZ = `CLKSM_RATE_MIN_HZ,
  parameter MAX_HZ = `CLKSM_RATE_MAX_HZ
) (
  input wire sys_clk,
  input wire nrst,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire madi_ref,
  input wire wc_ref,
  input wire aes_ref,
  output reg sample_tick,
  output reg wc_out
);
  localparam W = 16;
  localparam integer MIN_PER_I = (SYS_HZ + MAX_HZ - 1) / MAX_HZ;
  localparam integer MAX_PER_I = SYS_HZ / MIN_HZ;
  localparam integer SS_PER_I = SYS_HZ / `CLKSM_SS_MAX_HZ;
  localparam integer DS_PER_I = SYS_HZ / `CLKSM_DS_MAX_HZ;
  // Period limits in sys_clk cycles; every one of them fits the counter width.
  localparam [W-1:0] MIN_PER = MIN_PER_I[W-1:0];
  localparam [W-1:0] MAX_PER = MAX_PER_I[W-1:0];
  localparam [W-1:0] SS_PER = SS_PER_I[W-1:0];
  localparam [W-1:0] DS_PER = DS_PER_I[W-1:0];
  localparam [W-1:0] SYNC_TOL = `CLKSM_SYNC_TOL;

  reg [3:0] ctrl;
  reg [W-1:0] int_per;
  reg [W-1:0] int_cnt;
  reg int_tick;
  reg [W-1:0] act_cnt;
  reg [W-1:0] act_per;
  reg act_valid;
  reg [W-1:0] wc_cnt;
  reg [W-1:0] wc_per;
  reg [1:0] src_used;
  reg [1:0] st_madi, st_wc, st_aes;
  reg [1:0] next_src;
  reg next_tick;
  wire m_lock, w_lock, a_lock;
  wire m_tick, w_tick, a_tick;
  wire [W-1:0] m_per, w_per, a_per;
  wire [1:0] src_sel = ctrl[`CLKSM_CTRL_SRC_LSB+1:`CLKSM_CTRL_SRC_LSB];
  wire follow = ctrl[`CLKSM_CTRL_FOLLOW_BIT];
  wire wc_from_madi = ctrl[`CLKSM_CTRL_WCMADI_BIT];
  wire [W-1:0] act_next = act_cnt + {{(W-1){1'b0}}, 1'b1};
  wire [W-1:0] wc_next = wc_cnt + {{(W-1){1'b0}}, 1'b1};
  wire wc_src_tick = wc_from_madi ? m_tick : sample_tick;
  wire [W-1:0] wc_src_per = wc_from_madi ? m_per : act_per;
  wire [W-1:0] wdata_per = reg_wdata[W-1:0];

  clksm_ref_meter #(
    .W(W),
    .CONVERT(0),
    .MIN_PER(MIN_PER),
    .MAX_PER(MAX_PER),
    .SS_PER(SS_PER),
    .DS_PER(DS_PER)
  ) u_madi (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ref_pin(madi_ref),
    .locked(m_lock),
    .tick(m_tick),
    .period(m_per)
  );

  // Only the word clock input folds double and quad rate references down to single speed.
  clksm_ref_meter #(
    .W(W),
    .CONVERT(1),
    .MIN_PER(MIN_PER),
    .MAX_PER(MAX_PER),
    .SS_PER(SS_PER),
    .DS_PER(DS_PER)
  ) u_wc (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ref_pin(wc_ref),
    .locked(w_lock),
    .tick(w_tick),
    .period(w_per)
  );

  clksm_ref_meter #(
    .W(W),
    .CONVERT(0),
    .MIN_PER(MIN_PER),
    .MAX_PER(MAX_PER),
    .SS_PER(SS_PER),
    .DS_PER(DS_PER)
  ) u_aes (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ref_pin(aes_ref),
    .locked(a_lock),
    .tick(a_tick),
    .period(a_per)
  );

  // Sync means the reference period is within one cycle of the valid period of the clock that reads the data.
  function [1:0] ref_state;
    input lock;
    input [W-1:0] per;
    input [W-1:0] aper;
    input avalid;
    reg [W-1:0] d;
    begin
      d = (per > aper) ? per - aper : aper - per;
      if (!lock)
        ref_state = `CLKSM_ST_NOLOCK; // RULE4
      else if (avalid && d <= SYNC_TOL)
        ref_state = `CLKSM_ST_SYNC; // RULE5
      else
        ref_state = `CLKSM_ST_LOCK; // RULE5
    end
  endfunction

  // Follow mode falls back to the internal generator while the chosen reference has no lock.
  always @* begin
    next_src = `CLKSM_SRC_INT; // RULE7
    next_tick = int_tick;
    if (follow) begin
      case (src_sel)
        `CLKSM_SRC_MADI: begin
          if (m_lock) begin
            next_src = `CLKSM_SRC_MADI; // RULE1
            next_tick = m_tick;
          end
        end
        `CLKSM_SRC_WC: begin
          if (w_lock) begin
            next_src = `CLKSM_SRC_WC; // RULE1
            next_tick = w_tick;
          end
        end
        `CLKSM_SRC_AES: begin
          if (a_lock) begin
            next_src = `CLKSM_SRC_AES; // RULE1
            next_tick = a_tick;
          end
        end
        default: begin
          next_src = `CLKSM_SRC_INT;
          next_tick = int_tick;
        end
      endcase
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= `CLKSM_CTRL_RESET;
      int_per <= `CLKSM_RATE_RESET;
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= 32'h00000000;
      if (reg_wr) begin
        case (reg_addr)
          `CLKSM_REG_CTRL: ctrl <= reg_wdata[3:0];
          `CLKSM_REG_RATE: begin
            if (wdata_per < MIN_PER)
              int_per <= MIN_PER; // RULE2
            else if (wdata_per > MAX_PER)
              int_per <= MAX_PER; // RULE2
            else
              int_per <= wdata_per;
          end
          default: ctrl <= ctrl;
        endcase
      end
      if (reg_rd) begin
        case (reg_addr)
          `CLKSM_REG_CTRL: reg_rdata <= {28'h0000000, ctrl};
          `CLKSM_REG_RATE: reg_rdata <= {16'h0000, int_per};
          `CLKSM_REG_STATUS: reg_rdata <= {22'h000000, act_valid, (follow && src_sel != src_used),
            src_used, st_aes, st_wc, st_madi}; // RULE11
          `CLKSM_REG_PERIOD: reg_rdata <= {16'h0000, act_per};
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      int_cnt <= 16'h0000;
      int_tick <= 1'b0;
      sample_tick <= 1'b0;
      src_used <= `CLKSM_SRC_INT;
      act_cnt <= 16'h0000;
      act_per <= 16'h0000;
      act_valid <= 1'b0;
      st_madi <= `CLKSM_ST_NOLOCK;
      st_wc <= `CLKSM_ST_NOLOCK;
      st_aes <= `CLKSM_ST_NOLOCK;
      wc_cnt <= 16'h0000;
      wc_per <= 16'h0000;
      wc_out <= 1'b0;
    end else begin
      int_tick <= 1'b0;
      if (int_cnt + 16'h0001 >= int_per) begin
        int_cnt <= 16'h0000;
        int_tick <= 1'b1; // RULE7
      end else
        int_cnt <= int_cnt + 16'h0001;
      sample_tick <= next_tick;
      if (src_used != next_src)
        act_valid <= 1'b0;
      src_used <= next_src;
      if (act_cnt != {W{1'b1}})
        act_cnt <= act_next;
      if (sample_tick) begin
        act_cnt <= 16'h0000;
        act_per <= act_next;
        act_valid <= (act_next >= MIN_PER) && (act_next <= MAX_PER); // RULE2
      end
      st_madi <= ref_state(m_lock, m_per, act_per, act_valid); // RULE6 RULE11
      st_wc <= ref_state(w_lock, w_per, act_per, act_valid); // RULE11
      st_aes <= ref_state(a_lock, a_per, act_per, act_valid); // RULE11
      // The word clock output is high for the first half of each wc_src_tick period; following MADI without lock, it drops after one cycle.
      if (wc_src_tick) begin
        wc_cnt <= 16'h0000;
        wc_per <= wc_src_per; // RULE8 RULE9
        wc_out <= 1'b1;
      end else begin
        if (wc_cnt != {W{1'b1}})
          wc_cnt <= wc_next;
        if (wc_next >= {1'b0, wc_per[W-1:1]} || (wc_from_madi && !m_lock))
          wc_out <= 1'b0; // RULE9
      end
    end
  end
endmodule // clksm_top

/* clksm_monitor.sv */
/* Port checker for clksm_top. Assumes it is bound to clksm_top and sees only its ports. */
`timescale 1ns/1ps
module clksm_monitor (
  input wire sys_clk,
  input wire nrst,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire madi_ref,
  input wire wc_ref,
  input wire aes_ref,
  input wire sample_tick,
  input wire wc_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [15:0] gap;
  logic wr0_d;
  // A control write may switch the tick source, so the spacing count is set to its maximum after it.
  always @(posedge sys_clk or negedge nrst)
    if (!nrst) begin
      gap <= 16'h0000;
      wr0_d <= 1'b0;
    end else begin
      wr0_d <= reg_wr && reg_addr == 4'h0;
      if ((reg_wr && reg_addr == 4'h0) || wr0_d) gap <= 16'hFFFF;
      else if (sample_tick) gap <= 16'h0000;
      else if (gap != 16'hFFFF) gap <= gap + 16'h0001;
    end
  sequence s_wr0; reg_wr && reg_addr == 4'h0; endsequence
  sequence s_rd0; reg_rd && reg_addr == 4'h0; endsequence
  sequence s_rd8; reg_rd && reg_addr == 4'h8; endsequence
  AST_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("rdata not idle");
  AST_HOLE: assert property (reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0) else $error("hole");
  AST_CODE: assert property (s_rd8 |=> !(&reg_rdata[1:0] || &reg_rdata[3:2] || &reg_rdata[5:4]))
    else $error("bad state code");
  AST_FALL: assert property (s_rd8 ##1 reg_rdata[8] |-> reg_rdata[7:6] == 2'h0) else $error("fallback");
  AST_RATE: assert property (reg_rd && reg_addr == 4'h4 |=> reg_rdata inside {[32'h3E8:32'h1BE6]})
    else $error("rate range");
  AST_PULSE: assert property (sample_tick |=> !sample_tick) else $error("tick width");
  AST_MIN: assert property (sample_tick |-> gap >= 16'h03E7) else $error("tick too soon");
  AST_BACK: assert property (s_wr0 ##1 !reg_wr ##1 s_rd0 |=> reg_rdata[3:0] == $past(reg_wdata[3:0], 3))
    else $error("ctrl readback");
endmodule // clksm_monitor
bind clksm_top clksm_monitor u_clksm_monitor (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .madi_ref(madi_ref),
  .wc_ref(wc_ref), .aes_ref(aes_ref), .sample_tick(sample_tick), .wc_out(wc_out));

/* clksm_ref_src.sv */
/* Reference clock source for one pin. Assumes a half period in ns; the pin rests low while disabled. */
`timescale 1ns/1ps
module clksm_ref_src (
  input wire en,
  input wire [31:0] half_ns,
  output logic ref_pin
);
  initial begin
    ref_pin = 1'b0;
    forever begin
      if (en) #(half_ns) ref_pin = ~ref_pin;
      else begin
        ref_pin = 1'b0;
        @(en);
      end
    end
  end
endmodule // clksm_ref_src

/* tb.sv */
/* Self-checking bench for clksm_top. Assumes the bound checker and three clksm_ref_src sources. */
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d, wc_d, m_en = 1'b0, a_en = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, v;
  wire [31:0] reg_rdata;
  wire madi_ref, wc_ref, aes_ref, sample_tick, wc_out;
  int error_cnt, check_count, seed, n;
  logic [31:0] e_q[$], m_q[$];
  string s_q[$];
  clksm_top u_clksm_top (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .madi_ref(madi_ref), .wc_ref(wc_ref),
    .aes_ref(aes_ref), .sample_tick(sample_tick), .wc_out(wc_out));
  // MADI runs at 4170 cycles, word clock at 1042 cycles (a quarter of 4168), AES far above the range.
  clksm_ref_src u_madi_src (.en(m_en), .half_ns(32'h28B9), .ref_pin(madi_ref));
  clksm_ref_src u_wc_src (.en(a_en), .half_ns(32'hA2D), .ref_pin(wc_ref));
  clksm_ref_src u_aes_src (.en(a_en), .half_ns(32'h20), .ref_pin(aes_ref));
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    wc_d <= wc_out;
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  always @(negedge sys_clk)
    if (rd_d === 1'b1) chk(s_q.pop_front(), e_q.pop_front(), reg_rdata & m_q.pop_front());
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m, input string s);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    e_q.push_back(e & m);
    m_q.push_back(m);
    s_q.push_back(s);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic gap(input logic w, output int g);
    int c;
    int t;
    c = 0;
    t = 0;
    g = 0;
    while (c < 2 && t < 30000) begin
      @(negedge sys_clk);
      t++;
      if (c == 1) g++;
      if (w ? (wc_out && !wc_d) : sample_tick) c++;
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #550000;
    error_cnt++;
    test_done;
  end
  initial begin
    seed = 10100;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(4'h0, 32'h0, 32'hF, "ctrl reset");
    rd(4'h4, 32'h1046, 32'hFFFFFFFF, "rate reset");
    rd(4'h8, 32'h0, 32'h1FF, "status idle");
    rd(4'h6, 32'h0, 32'hFFFFFFFF, "hole");
    gap(1'b0, n);
    chk("internal tick", 32'h1046, n);
    for (int k = 0; k < 4; k++) begin
      wr(4'h0, k);
      rd(4'h0, k, 32'hF, "ctrl");
    end
    $display("reset and control done");
    v = 32'h3E8 + {$random(seed)} % 32'h17FF;
    wr(4'h4, 32'h10);
    rd(4'h4, 32'h3E8, 32'hFFFF, "rate floor");
    wr(4'h4, 32'hFFFF);
    rd(4'h4, 32'h1BE6, 32'hFFFF, "rate ceiling");
    wr(4'h4, v);
    rd(4'h4, v, 32'hFFFF, "rate random");
    wr(4'h4, 32'h1046);
    $display("rate done");
    #1.3;
    m_en = 1'b1;
    a_en = 1'b1;
    repeat (36000) @(posedge sys_clk);
    rd(4'h8, 32'h5, 32'h1FF, "status master");
    wr(4'h4, 32'h1048);
    repeat (9000) @(posedge sys_clk);
    rd(4'h8, 32'h9, 32'h1FF, "status wc sync");
    wr(4'h4, 32'h1046);
    wr(4'h0, 32'hD);
    repeat (14000) @(posedge sys_clk);
    rd(4'h8, 32'h46, 32'h1FF, "status follow");
    rd(4'hC, 32'h104A, 32'hFFFF, "period");
    gap(1'b0, n);
    chk("follow tick", 32'h104A, n);
    gap(1'b1, n);
    chk("wc out", 32'h104A, n);
    $display("follow done");
    m_en = 1'b0;
    repeat (9000) @(posedge sys_clk);
    rd(4'h8, 32'h104, 32'h1FF, "status fallback");
    @(negedge sys_clk);
    chk("wc out idle", 32'h0, {31'h0, wc_out});
    $display("fallback done");
    test_done;
  end
endmodule // tb
